/* File: verilog/pfs_pkg.sv */
package pfs_pkg;

	// Clock and line timing, in nanoseconds and in cycles.
	localparam int CLK_PERIOD_NS = 10;
	localparam int SYNC_LOW_NS = 500;
	localparam int SHARE_PERIOD_NS = 10000;
	localparam int SHARE_LOW_NS = 1000;
	localparam int SYNC_LOW_CYC = (SYNC_LOW_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SHARE_PERIOD_CYC = SHARE_PERIOD_NS / CLK_PERIOD_NS;
	localparam int SHARE_LOW_CYC = (SHARE_LOW_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int SYNC_PERIOD_CYC_DFLT = 400;

	// Channel and fault source layout.
	localparam int NCH = 2;
	localparam int NSRC = 5;
	localparam int SRC_OV = 0;
	localparam int SRC_UV = 1;
	localparam int SRC_OC = 2;
	localparam int SRC_OT = 3;
	localparam int SRC_TMG = 4;
	localparam int DLY_W = 16;

	// Addressing and unlock sequence of the uninitialised memory state.
	localparam logic [6:0] UNINIT_ADDR_A = 7'h5A;
	localparam logic [6:0] UNINIT_ADDR_B = 7'h5B;
	localparam logic [7:0] UNLOCK_CMD = 8'hBD;
	localparam logic [7:0] UNLOCK_KEY1 = 8'h2B;
	localparam logic [7:0] UNLOCK_KEY2 = 8'hC4;

	// Common status layout and reset value.
	localparam int STAT_NVM_INIT_BIT = 3;
	localparam logic [7:0] COMMON_STATUS_RST = 8'h00;

	// Alert flag positions.
	localparam int ALR_COMM = 0;
	localparam int ALR_HELD = 1;
	localparam int ALR_EXT = 2;
	localparam int NALR = 3;

	// Gate drive level codes and targets in millivolts.
	localparam logic [1:0] DRV_CODE_6V3 = 2'h0;
	localparam logic [1:0] DRV_CODE_7V4 = 2'h1;
	localparam logic [1:0] DRV_CODE_9V0 = 2'h2;
	localparam logic [13:0] DRV_MV_6V3 = 14'h189C;
	localparam logic [13:0] DRV_MV_7V4 = 14'h1CE8;
	localparam logic [13:0] DRV_MV_9V0 = 14'h2328;

	typedef enum logic [1:0] {
		RESP_IGNORE = 2'b00,
		RESP_LATCH = 2'b01,
		RESP_RETRY = 2'b10
	} pfs_resp_e;

	typedef enum logic [1:0] {
		ST_LOCKOUT = 2'b00,
		ST_WAIT_IN = 2'b01,
		ST_ACTIVE = 2'b10
	} pfs_state_e;

	typedef enum logic [2:0] {
		CH_IDLE = 3'b000,
		CH_WAIT = 3'b001,
		CH_ON = 3'b010,
		CH_LATCH = 3'b011,
		CH_RETRY = 3'b100
	} pfs_ch_e;

	// Maps the drive level code to its target; code 3 falls back to 6.3V.
	function automatic logic [13:0] drv_target_mv(input logic [1:0] sel);
		logic [13:0] mv;
		mv = DRV_MV_6V3;
		if (sel == DRV_CODE_7V4)
			mv = DRV_MV_7V4;
		else if (sel == DRV_CODE_9V0)
			mv = DRV_MV_9V0;
		return mv;
	endfunction : drv_target_mv

endpackage : pfs_pkg

/* File: verilog/pfs_sync2.sv */
`timescale 1ns/100ps
module pfs_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;

	// Two-stage synchroniser; the first stage feeds only the second.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta <= '0;
			q <= '0;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule : pfs_sync2

/* File: verilog/pfs_pulse_gen.sv */
`timescale 1ns/100ps
module pfs_pulse_gen #(
	parameter int PERIOD = 1000,
	parameter int LOW = 100
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic en,
	input wire logic hold_low,
	output logic pull_low
);
	localparam int CW = $clog2(PERIOD);
	localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);
	localparam logic [CW-1:0] LOWV = CW'(LOW);

	logic [CW-1:0] cnt;
	wire logic wrap = (cnt == LAST);
	wire logic in_low = en && (cnt < LOWV);

	// Period counter; each period opens with the pulled-low phase.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= '0;
			pull_low <= 1'b0;
		end else begin
			cnt <= (!en || wrap) ? '0 : cnt + 1'b1;
			pull_low <= hold_low || in_low;
		end
	end
endmodule : pfs_pulse_gen

/* File: verilog/pfs_powerup_seq.sv */
`timescale 1ns/100ps
// How it works
// RQ1: Sequencing waits for input above turn-on level.
// RQ2: Below turn-off: hold timebase low, restart normally.
// RQ3: Leave lockout on supplies; release run on 3V3.
// RQ4: Held fault line at power-apply always alerts.
// RQ5: Transaction cut by reset counts as comm fault.
// RQ6: Communication fault pulls the alert line low.
// RQ7: Logic supply alone runs bus, never power stages.
// RQ8: Status bit 3 low while input never applied.
// RQ9: Uninitialised: acknowledge only addresses 5A, 5B.
// RQ10: Host unlock sequence restores configured address.
// RQ11: Host stores all settings after configuring.
// RQ12: After programming, PWM and ADC wait for restart.
// RQ13: Fault line pulled low by selected fault kinds.
// RQ14: Fault line sensed as input while driven.
// RQ15: Fault response: ignore, latch off, or retry.
// RQ16: Overvoltage forces top gate on, bottom low.
// RQ17: Sync line pulsed low 500ns each period.
// RQ18: Timebase period 10us, low for 1us.
// RQ19: Drive level code selects 6.3, 7.4 or 9V.
// RQ20: Turn-on wait after run release before ramp.
// RQ21: Alert stays low until host clears flag.
// RQ22: Retry interval then full restart with wait.
module pfs_powerup_seq
	import pfs_pkg::*;
#(
	parameter int SYNC_PERIOD_CYC = pfs_pkg::SYNC_PERIOD_CYC_DFLT
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic SYS_RST,
	// Supply and input comparators.
	input wire logic BIAS_SUPPLY_OK,
	input wire logic RAILS_OK,
	input wire logic LOGIC_SUPPLY_3V3_OK,
	input wire logic INPUT_ABOVE_TURN_ON,
	input wire logic INPUT_BELOW_TURN_OFF,
	// Run line.
	input wire logic RUN_LINE_IN,
	output logic RUN_LINE_OUT,
	output logic RUN_LINE_OE,
	// Shared timebase line.
	input wire logic SHARE_IN,
	output logic SHARE_OUT,
	output logic SHARE_OE,
	// Sync line.
	input wire logic SYNC_EN,
	output logic SYNC_OUT,
	output logic SYNC_OE,
	// Channel fault lines.
	input wire logic [pfs_pkg::NCH-1:0] CHANNEL_FAULT_LINE_IN,
	output logic [pfs_pkg::NCH-1:0] CHANNEL_FAULT_LINE_OUT,
	output logic [pfs_pkg::NCH-1:0] CHANNEL_FAULT_LINE_OE,
	// Fault detectors, one bit per channel.
	input wire logic [pfs_pkg::NCH-1:0] OV_DET,
	input wire logic [pfs_pkg::NCH-1:0] UV_DET,
	input wire logic [pfs_pkg::NCH-1:0] OC_DET,
	input wire logic [pfs_pkg::NCH-1:0] OT_DET,
	input wire logic [pfs_pkg::NCH-1:0] TMG_DET,
	// Fault configuration.
	input wire logic [pfs_pkg::NCH*pfs_pkg::NSRC-1:0] FLT_PROP_MASK,
	input wire logic [2*pfs_pkg::NCH-1:0] FLT_RESP,
	input wire logic [pfs_pkg::NCH-1:0] FLT_LISTEN,
	// Sequencing delays in timebase ticks.
	input wire logic [pfs_pkg::DLY_W-1:0] TURN_ON_WAIT,
	input wire logic [pfs_pkg::DLY_W-1:0] RETRY_INTERVAL,
	// Gate drive.
	input wire logic [pfs_pkg::NCH-1:0] PWM_TOP_REQ,
	input wire logic [pfs_pkg::NCH-1:0] PWM_BOT_REQ,
	output logic [pfs_pkg::NCH-1:0] TOP_GATE_OUT,
	output logic [pfs_pkg::NCH-1:0] BOTTOM_GATE_OUT,
	output logic [pfs_pkg::NCH-1:0] PWM_EN,
	output logic ADC_VALID,
	input wire logic [1:0] GATE_DRIVE_LEVEL_SEL,
	output logic [13:0] DRV_TARGET_MV,
	// Decoded management bus events.
	input wire logic BUS_BUSY,
	input wire logic BUS_ADDR_STB,
	input wire logic [6:0] BUS_ADDR,
	input wire logic BUS_WR_STB,
	input wire logic [7:0] BUS_CMD,
	input wire logic [7:0] BUS_DATA,
	input wire logic BUS_ABORT,
	input wire logic SOFT_RESTART_CMD,
	input wire logic [6:0] CFG_ADDR,
	output logic BUS_ACK,
	// Alert and status.
	input wire logic ALERT_MASK_HELD,
	input wire logic [pfs_pkg::NALR-1:0] ALERT_CLR,
	output logic ALERT_OUT,
	output logic ALERT_OE,
	output logic [pfs_pkg::NALR-1:0] ALERT_STATUS,
	output logic [7:0] COMMON_STATUS_CMD
);
	// Seven single inputs plus six inputs per channel.
	localparam int NS = 7 + 6 * NCH;

	// Synchronised copies of the supply, comparator, line and fault detector inputs.
	logic [NS-1:0] pin_raw;
	logic [NS-1:0] pin_s;
	// Idle-high wires pass inverted, so the cleared stages read as idle.
	assign pin_raw = {TMG_DET, OT_DET, OC_DET, UV_DET, OV_DET,
		~CHANNEL_FAULT_LINE_IN, ~SHARE_IN, ~RUN_LINE_IN,
		INPUT_BELOW_TURN_OFF, INPUT_ABOVE_TURN_ON,
		LOGIC_SUPPLY_3V3_OK, RAILS_OK, BIAS_SUPPLY_OK};

	pfs_sync2 #(.W(NS)) u_sync (
		.clk(CLK),
		.rst(SYS_RST),
		.d(pin_raw),
		.q(pin_s)
	);

	wire logic bias_ok = pin_s[0];
	wire logic rails_ok = pin_s[1];
	wire logic logic_ok = pin_s[2];
	wire logic in_on = pin_s[3];
	wire logic in_off = pin_s[4];
	wire logic run_in = !pin_s[5];
	wire logic share_in = !pin_s[6];
	wire logic [NCH-1:0] fault_in = ~pin_s[7 +: NCH];
	wire logic [NCH-1:0] ov_s = pin_s[7 + NCH +: NCH];
	wire logic [NCH-1:0] uv_s = pin_s[7 + 2 * NCH +: NCH];
	wire logic [NCH-1:0] oc_s = pin_s[7 + 3 * NCH +: NCH];
	wire logic [NCH-1:0] ot_s = pin_s[7 + 4 * NCH +: NCH];
	wire logic [NCH-1:0] tmg_s = pin_s[7 + 5 * NCH +: NCH];

	// State.
	pfs_state_e state;
	pfs_state_e next_state;
	pfs_ch_e ch_state [NCH];
	pfs_ch_e next_ch_state [NCH];
	logic [DLY_W-1:0] ch_cnt [NCH];
	logic [DLY_W-1:0] next_ch_cnt [NCH];
	logic share_prev;
	logic bias_prev;
	logic first_cyc;
	logic in_seen;
	logic unlocked;
	logic unlock_step;
	logic cur_acked;
	logic [6:0] cur_addr;
	logic prog_mode;
	logic restart_pend;
	logic [NALR-1:0] alert_flag;
	logic [NALR-1:0] next_alert;
	logic [NCH-1:0] next_fault_oe;
	logic [NCH-1:0] ext_low;

	// Supply gating and sequencing permission.
	wire logic supplies_ok = bias_ok && rails_ok && logic_ok; // [RQ3]
	wire logic seq_ok = (state == ST_ACTIVE) && !restart_pend
		&& run_in; // [RQ1] [RQ12]
	wire logic tick = share_prev && !share_in;
	wire logic share_hold = (state != ST_ACTIVE); // [RQ2]

	// Supply and input sequencing.
	always_comb begin
		next_state = state;
		unique case (state)
			ST_LOCKOUT: begin
				if (supplies_ok)
					next_state = ST_WAIT_IN; // [RQ3]
			end
			ST_WAIT_IN: begin
				if (!supplies_ok)
					next_state = ST_LOCKOUT;
				else if (in_on)
					next_state = ST_ACTIVE; // [RQ1] [RQ2]
			end
			ST_ACTIVE: begin
				if (!supplies_ok)
					next_state = ST_LOCKOUT;
				else if (in_off || SOFT_RESTART_CMD)
					next_state = ST_WAIT_IN; // [RQ2]
			end
			default: next_state = ST_LOCKOUT;
		endcase
	end

	// Per-channel turn-on wait, run and fault response.
	always_comb begin
		logic [NSRC-1:0] src;
		logic flt;
		logic [1:0] resp;
		logic shut;
		src = '0;
		flt = 1'b0;
		resp = 2'b00;
		shut = 1'b0;
		for (int c = 0; c < NCH; c++) begin
			src = {tmg_s[c], ot_s[c], oc_s[c], uv_s[c], ov_s[c]};
			next_fault_oe[c] = |(src & FLT_PROP_MASK[c*NSRC +: NSRC]); // [RQ13]
			ext_low[c] = !fault_in[c] && !CHANNEL_FAULT_LINE_OE[c];
			flt = (|src) || (!fault_in[c] && FLT_LISTEN[c]); // [RQ14]
			resp = FLT_RESP[2*c +: 2];
			shut = flt && (resp == RESP_LATCH || resp == RESP_RETRY); // [RQ15]
			next_ch_state[c] = ch_state[c];
			next_ch_cnt[c] = ch_cnt[c];
			if (!seq_ok) begin
				next_ch_state[c] = CH_IDLE;
			end else begin
				unique case (ch_state[c])
					CH_IDLE: begin
						next_ch_state[c] = CH_WAIT; // [RQ20]
						next_ch_cnt[c] = TURN_ON_WAIT;
					end
					CH_WAIT, CH_ON: begin
						if (shut && resp == RESP_LATCH) begin
							next_ch_state[c] = CH_LATCH; // [RQ15]
						end else if (shut) begin
							next_ch_state[c] = CH_RETRY; // [RQ22]
							next_ch_cnt[c] = RETRY_INTERVAL;
						end else if (ch_state[c] == CH_WAIT) begin
							if (ch_cnt[c] == '0)
								next_ch_state[c] = CH_ON; // [RQ20]
							else if (tick)
								next_ch_cnt[c] = ch_cnt[c] - 1'b1;
						end
					end
					CH_RETRY: begin
						if (ch_cnt[c] == '0) begin
							next_ch_state[c] = CH_WAIT; // [RQ22]
							next_ch_cnt[c] = TURN_ON_WAIT;
						end else if (tick) begin
							next_ch_cnt[c] = ch_cnt[c] - 1'b1;
						end
					end
					CH_LATCH: next_ch_state[c] = CH_LATCH;
					default: next_ch_state[c] = CH_IDLE;
				endcase
			end
		end
	end

	// Address decode and unlock sequence detection.
	wire logic nvm_uninit = !in_seen && !unlocked;
	wire logic addr_ok = nvm_uninit
		? (BUS_ADDR == UNINIT_ADDR_A || BUS_ADDR == UNINIT_ADDR_B)
		: (BUS_ADDR == CFG_ADDR); // [RQ9]
	wire logic unlock_wr = BUS_WR_STB && cur_acked
		&& cur_addr == UNINIT_ADDR_B && BUS_CMD == UNLOCK_CMD;
	wire logic key1 = unlock_wr && BUS_DATA == UNLOCK_KEY1;
	wire logic key2 = unlock_wr && BUS_DATA == UNLOCK_KEY2
		&& unlock_step; // [RQ10]

	// Alert events; a new event wins over a clear in the same cycle.
	wire logic comm_evt = BUS_ABORT || (first_cyc && BUS_BUSY); // [RQ5]
	wire logic held_evt = in_on && !in_seen
		&& (fault_in != {NCH{1'b1}}); // [RQ4]
	wire logic ext_evt = (|ext_low) && !ALERT_MASK_HELD;
	wire logic [NALR-1:0] alert_set = {ext_evt, held_evt, comm_evt};
	assign next_alert = (alert_flag & ~ALERT_CLR) | alert_set; // [RQ21]

	// Restart request after memory programming from the logic supply.
	wire logic bias_rise = bias_ok && !bias_prev;
	wire logic restart_set = prog_mode && bias_rise;

	// Sequencing registers.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			state <= ST_LOCKOUT;
			share_prev <= 1'b0;
			bias_prev <= 1'b0;
		end else begin
			state <= next_state;
			share_prev <= share_in;
			bias_prev <= bias_ok;
		end
	end

	// Channel registers.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			for (int c = 0; c < NCH; c++) begin
				ch_state[c] <= CH_IDLE;
				ch_cnt[c] <= '0;
			end
		end else begin
			for (int c = 0; c < NCH; c++) begin
				ch_state[c] <= next_ch_state[c];
				ch_cnt[c] <= next_ch_cnt[c];
			end
		end
	end

	// Bus-facing state; runs from the logic supply alone.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			first_cyc <= 1'b1;
			cur_acked <= 1'b0;
			cur_addr <= 7'h00;
			unlock_step <= 1'b0;
			unlocked <= 1'b0;
			BUS_ACK <= 1'b0;
		end else begin
			first_cyc <= 1'b0;
			BUS_ACK <= BUS_ADDR_STB && addr_ok; // [RQ7] [RQ9]
			if (BUS_ADDR_STB) begin
				cur_acked <= addr_ok;
				cur_addr <= BUS_ADDR;
			end
			if (BUS_WR_STB)
				unlock_step <= key1;
			if (key2)
				unlocked <= 1'b1; // [RQ10]
		end
	end

	// Memory state, restart hold and alert flags.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			in_seen <= 1'b0;
			prog_mode <= 1'b0;
			restart_pend <= 1'b0;
			alert_flag <= '0;
		end else begin
			if (in_on)
				in_seen <= 1'b1; // [RQ8]
			if (logic_ok && !bias_ok)
				prog_mode <= 1'b1; // [RQ7]
			else if (SOFT_RESTART_CMD && !restart_set)
				prog_mode <= 1'b0;
			restart_pend <= restart_set
				|| (restart_pend && !SOFT_RESTART_CMD); // [RQ12]
			alert_flag <= next_alert; // [RQ6] [RQ21]
		end
	end

	// Sync line pulse generator.
	pfs_pulse_gen #(
		.PERIOD(SYNC_PERIOD_CYC),
		.LOW(SYNC_LOW_CYC)
	) u_sync_gen (
		.clk(CLK),
		.rst(SYS_RST),
		.en(SYNC_EN), // [RQ17]
		.hold_low(1'b0),
		.pull_low(SYNC_OE)
	);

	// Shared timebase generator, held low outside active sequencing.
	pfs_pulse_gen #(
		.PERIOD(SHARE_PERIOD_CYC),
		.LOW(SHARE_LOW_CYC)
	) u_share_gen (
		.clk(CLK),
		.rst(SYS_RST),
		.en(1'b1), // [RQ18]
		.hold_low(share_hold), // [RQ2]
		.pull_low(SHARE_OE)
	);

	// Gate, enable and status outputs.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			TOP_GATE_OUT <= '0;
			BOTTOM_GATE_OUT <= '0;
			PWM_EN <= '0;
			ADC_VALID <= 1'b0;
			DRV_TARGET_MV <= DRV_MV_6V3;
			COMMON_STATUS_CMD <= COMMON_STATUS_RST;
			CHANNEL_FAULT_LINE_OE <= '0;
			ALERT_OE <= 1'b0;
			ALERT_STATUS <= '0;
			RUN_LINE_OE <= 1'b1;
		end else begin
			for (int c = 0; c < NCH; c++) begin
				PWM_EN[c] <= (ch_state[c] == CH_ON); // [RQ7] [RQ12]
				TOP_GATE_OUT[c] <= ov_s[c]
					|| (ch_state[c] == CH_ON && PWM_TOP_REQ[c]); // [RQ16]
				BOTTOM_GATE_OUT[c] <= !ov_s[c]
					&& ch_state[c] == CH_ON && PWM_BOT_REQ[c]; // [RQ16]
			end
			ADC_VALID <= (state != ST_LOCKOUT) && !restart_pend; // [RQ12]
			DRV_TARGET_MV <= drv_target_mv(GATE_DRIVE_LEVEL_SEL); // [RQ19]
			COMMON_STATUS_CMD <= COMMON_STATUS_RST;
			COMMON_STATUS_CMD[STAT_NVM_INIT_BIT] <= in_seen; // [RQ8]
			CHANNEL_FAULT_LINE_OE <= next_fault_oe; // [RQ13]
			ALERT_OE <= |next_alert; // [RQ4] [RQ6]
			ALERT_STATUS <= next_alert;
			RUN_LINE_OE <= (next_state == ST_LOCKOUT); // [RQ3]
		end
	end

	// Open-drain data levels are always low; only the enables move.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RUN_LINE_OUT <= 1'b0;
			SHARE_OUT <= 1'b0;
			SYNC_OUT <= 1'b0;
			CHANNEL_FAULT_LINE_OUT <= '0;
			ALERT_OUT <= 1'b0;
		end else begin
			RUN_LINE_OUT <= 1'b0;
			SHARE_OUT <= 1'b0;
			SYNC_OUT <= 1'b0;
			CHANNEL_FAULT_LINE_OUT <= '0;
			ALERT_OUT <= 1'b0;
		end
	end
endmodule : pfs_powerup_seq

/* File: verif/pfs_checker_properties.sv */
`timescale 1ns/100ps
module pfs_checker #(
	parameter int SYNC_PERIOD_CYC = 400
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic SYS_RST,
	// Watched ports.
	input wire logic LOGIC_SUPPLY_3V3_OK,
	input wire logic INPUT_BELOW_TURN_OFF,
	input wire logic RUN_LINE_OE,
	input wire logic SHARE_OE,
	input wire logic SYNC_EN,
	input wire logic SYNC_OE,
	input wire logic [1:0] OV_DET,
	input wire logic [1:0] TOP_GATE_OUT,
	input wire logic [1:0] BOTTOM_GATE_OUT,
	input wire logic [1:0] PWM_EN,
	input wire logic [1:0] GATE_DRIVE_LEVEL_SEL,
	input wire logic [13:0] DRV_TARGET_MV,
	input wire logic BUS_ABORT,
	input wire logic BUS_ADDR_STB,
	input wire logic [6:0] BUS_ADDR,
	input wire logic [6:0] CFG_ADDR,
	input wire logic BUS_ACK,
	input wire logic [2:0] ALERT_CLR,
	input wire logic ALERT_OE,
	input wire logic [2:0] ALERT_STATUS,
	input wire logic [7:0] COMMON_STATUS_CMD
);
	int sync_run;
	int share_run;
	int pwm_on;
	// Run lengths of line pulls and of both channels being on.
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			sync_run <= 0;
			share_run <= 0;
			pwm_on <= 0;
		end else begin
			sync_run <= SYNC_OE ? sync_run + 1 : 0;
			share_run <= SHARE_OE ? share_run + 1 : 0;
			pwm_on <= (PWM_EN == 2'h3) ? pwm_on + 1 : 0;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	// Overvoltage seen long enough to pass the synchronisers.
	sequence ov_held;
		(OV_DET == 2'h3) [*5];
	endsequence
	sequence abort_seen;
		BUS_ABORT ##1 1'b1;
	endsequence
	a_ov_gate_force: assert property (
		ov_held |-> TOP_GATE_OUT == 2'h3 && BOTTOM_GATE_OUT == 2'h0)
		else $error("gates not forced by overvoltage");
	a_drv_level_map: assert property (
		$stable(GATE_DRIVE_LEVEL_SEL) |-> DRV_TARGET_MV ==
		($past(GATE_DRIVE_LEVEL_SEL) == 2'h1 ? 14'h1CE8 :
		$past(GATE_DRIVE_LEVEL_SEL) == 2'h2 ? 14'h2328 : 14'h189C))
		else $error("drive target does not match level code");
	a_ack_addr_match: assert property (
		BUS_ACK |-> $past(BUS_ADDR_STB) && ($past(BUS_ADDR) == CFG_ADDR
		|| ($past(BUS_ADDR[6:1]) == 6'h2D && !COMMON_STATUS_CMD[3])))
		else $error("acknowledge for an address not served");
	a_below_hold: assert property (
		INPUT_BELOW_TURN_OFF [*8] |-> SHARE_OE && PWM_EN == 2'h0)
		else $error("timebase not held low below turn-off");
	a_sync_width: assert property (
		$fell(SYNC_OE) && SYNC_EN |-> sync_run == 50)
		else $error("sync pull has wrong length");
	a_share_width: assert property (
		$fell(SHARE_OE) && pwm_on > 200 |-> share_run == 100)
		else $error("timebase pull has wrong length");
	a_run_release: assert property (
		$fell(RUN_LINE_OE) |-> $past(LOGIC_SUPPLY_3V3_OK, 3))
		else $error("run line released without logic supply");
	a_comm_alert: assert property (
		abort_seen |-> ALERT_OE && ALERT_STATUS[0])
		else $error("no alert after communication fault");
	a_alert_sticky: assert property (
		ALERT_STATUS[0] && !ALERT_CLR[0] |=> ALERT_STATUS[0] && ALERT_OE)
		else $error("alert dropped without clear");
	a_pwm_after_input: assert property (
		PWM_EN != 2'h0 |-> COMMON_STATUS_CMD[3])
		else $error("channel on before input applied");
endmodule : pfs_checker
bind pfs_powerup_seq pfs_checker #(.SYNC_PERIOD_CYC(SYNC_PERIOD_CYC))
	u_pfs_checker (.*);

/* File: verif/pfs_peer_model.sv */
`timescale 1ns/100ps
module pfs_peer_model (
	// Peer controls.
	input wire logic link_en,
	input wire logic [1:0] fault_pull,
	// Device pull-down enables.
	input wire logic share_oe,
	input wire logic run_oe,
	input wire logic [1:0] fault_oe,
	// Resolved wires.
	output logic share_wire,
	output logic run_wire,
	output logic [1:0] fault_wire
);
	logic peer_share = 1'b0;
	// Faster peer timebase, 80ns period, still while not enabled.
	initial begin
		forever begin
			#60;
			peer_share = link_en;
			#20;
			peer_share = 1'b0;
		end
	end
	// Pull-ups return every released wire high; peers may pull faults.
	assign share_wire = !(share_oe || peer_share);
	assign run_wire = !run_oe;
	assign fault_wire = ~(fault_oe | fault_pull);
endmodule : pfs_peer_model

/* File: verif/tb_pfs_powerup_seq.sv */
`timescale 1ns/100ps
module tb_pfs_powerup_seq;
	import pfs_pkg::*;
	typedef struct {string nm; int idx; logic [15:0] exp;} pfs_note_s;
	logic CLK = 0, SYS_RST = 1, bias = 0, rails = 0, v33 = 0, above = 0;
	logic below = 0, addr_stb = 0, wr_stb = 0, abort = 0, busy = 1;
	logic restart = 0, link_en = 0, probe = 0, sync_en = 1, sync_oe;
	// Arbitrary code for the store-all-settings command.
	localparam logic [7:0] STORE_ALL = 8'h3C;
	logic [1:0] ov = 0, uv = 0, oc = 0, ot = 0, tmg = 0, drv_sel = 0;
	logic [1:0] top_req = 0, bot_req = 0, fpull = 0, flt_w, flt_oe;
	logic [1:0] top, bot, pwm_en, flt_listen = 0;
	logic [9:0] prop_mask = 0;
	logic [3:0] resp = 0;
	logic [6:0] addr = 0, ra;
	logic [7:0] cmd = 0, data = 0, cstat;
	logic [2:0] aclr = 0, alert_st;
	logic share_w, run_w, run_oe, share_oe, bus_ack, adc_valid;
	logic [13:0] drv_mv;
	int mismatches = 0, n_checks = 0, seed = 77290, ix;
	pfs_note_s notes[$];
	pfs_note_s cur;
	// Device under test with a short sync period.
	pfs_powerup_seq #(.SYNC_PERIOD_CYC(80)) u_pfs_powerup_seq (
		.CLK(CLK), .SYS_RST(SYS_RST), .BIAS_SUPPLY_OK(bias),
		.RAILS_OK(rails), .LOGIC_SUPPLY_3V3_OK(v33),
		.INPUT_ABOVE_TURN_ON(above), .INPUT_BELOW_TURN_OFF(below),
		.RUN_LINE_IN(run_w), .RUN_LINE_OUT(), .RUN_LINE_OE(run_oe),
		.SHARE_IN(share_w), .SHARE_OUT(), .SHARE_OE(share_oe),
		.SYNC_EN(sync_en), .SYNC_OUT(), .SYNC_OE(sync_oe),
		.CHANNEL_FAULT_LINE_IN(flt_w), .CHANNEL_FAULT_LINE_OUT(),
		.CHANNEL_FAULT_LINE_OE(flt_oe), .OV_DET(ov), .UV_DET(uv),
		.OC_DET(oc), .OT_DET(ot), .TMG_DET(tmg), .FLT_PROP_MASK(prop_mask),
		.FLT_RESP(resp), .FLT_LISTEN(flt_listen), .TURN_ON_WAIT(16'h0003),
		.RETRY_INTERVAL(16'h0004), .PWM_TOP_REQ(top_req),
		.PWM_BOT_REQ(bot_req), .TOP_GATE_OUT(top), .BOTTOM_GATE_OUT(bot),
		.PWM_EN(pwm_en), .ADC_VALID(adc_valid),
		.GATE_DRIVE_LEVEL_SEL(drv_sel), .DRV_TARGET_MV(drv_mv),
		.BUS_BUSY(busy), .BUS_ADDR_STB(addr_stb), .BUS_ADDR(addr),
		.BUS_WR_STB(wr_stb), .BUS_CMD(cmd), .BUS_DATA(data),
		.BUS_ABORT(abort), .SOFT_RESTART_CMD(restart),
		.CFG_ADDR(7'h40), .BUS_ACK(bus_ack), .ALERT_MASK_HELD(1'b1),
		.ALERT_CLR(aclr), .ALERT_OUT(), .ALERT_OE(),
		.ALERT_STATUS(alert_st), .COMMON_STATUS_CMD(cstat));
	pfs_peer_model u_pfs_peer_model (.link_en(link_en),
		.fault_pull(fpull), .share_oe(share_oe), .run_oe(run_oe),
		.fault_oe(flt_oe), .share_wire(share_w), .run_wire(run_w),
		.fault_wire(flt_w));
	// Clock and random modulator requests.
	initial forever #5 CLK = ~CLK;
	always @(posedge CLK) begin
		top_req <= 2'($random(seed));
		bot_req <= 2'($random(seed));
	end
	// Selects the output that a note refers to.
	function automatic logic [15:0] act(input int i);
		case (i)
			0: act = {15'h0, bus_ack};
			1: act = {14'h0, alert_st[1:0]};
			2: act = {15'h0, cstat[3]};
			3: act = {2'h0, drv_mv};
			4: act = {14'h0, pwm_en};
			5: act = {12'h0, top, bot};
			6: act = {15'h0, share_oe};
			7: act = {14'h0, flt_oe};
			8: act = {15'h0, run_oe};
			9: act = {15'h0, adc_valid};
			default: act = {15'h0, sync_oe};
		endcase
	endfunction : act
	// Watcher compares each probed output with the oldest note.
	always @(negedge CLK) begin
		if (probe) begin
			cur = notes.pop_front();
			n_checks++;
			if (act(cur.idx) !== cur.exp) begin
				mismatches++;
				$display("wrong value %s exp %h got %h", cur.nm, cur.exp,
					act(cur.idx));
			end
		end
	end
	task automatic tick(input int n);
		repeat (n) @(posedge CLK);
	endtask : tick
	task automatic test_done();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input int i, input logic [15:0] e);
		notes.push_back('{nm, i, e});
		probe <= 1'b1;
		tick(1);
		probe <= 1'b0;
		tick(1);
	endtask : chk
	// Bounded wait; running out counts as a mismatch and ends the run.
	task automatic wait_for(input int i, input logic [15:0] e, input int b);
		int k;
		for (k = 0; k < b; k++) begin
			@(negedge CLK);
			if (act(i) === e)
				break;
		end
		@(posedge CLK);
		if (k == b) begin
			mismatches++;
			$display("wrong value wait %0d exp %h got %h", i, e, act(i));
			test_done();
		end
	endtask : wait_for
	// Address phase; the acknowledge stands in the following cycle.
	task automatic bus_addr(input logic [6:0] a, input logic e);
		addr_stb <= 1'b1;
		addr <= a;
		tick(1);
		addr_stb <= 1'b0;
		chk("bus_ack", 0, {15'h0, e});
	endtask : bus_addr
	task automatic bus_wr(input logic [7:0] c, input logic [7:0] d);
		wr_stb <= 1'b1;
		cmd <= c;
		data <= d;
		tick(1);
		wr_stb <= 1'b0;
		tick(1);
	endtask : bus_wr
	// Main sequence, bus busy across the release of reset.
	initial begin
		tick(6);
		SYS_RST <= 1'b0;
		tick(1);
		busy <= 1'b0;
		tick(3);
		chk("alert_comm", 1, 16'h1);
		aclr <= 3'h7;
		tick(1);
		aclr <= 3'h0;
		v33 <= 1'b1;
		tick(10);
		chk("run_oe", 8, 16'h1);
		chk("pwm_en", 4, 16'h0);
		chk("nvm_bit", 2, 16'h0);
		for (ix = 0; ix < 4; ix++) begin
			ra = 7'($random(seed));
			bus_addr(ra, ra[6:1] == 6'h2D);
		end
		bus_addr(7'h40, 1'b0);
		bus_addr(7'h5A, 1'b1);
		bus_addr(7'h5B, 1'b1);
		bus_wr(UNLOCK_CMD, UNLOCK_KEY1);
		bus_wr(UNLOCK_CMD, UNLOCK_KEY2);
		bus_addr(7'h40, 1'b1);
		bus_wr(STORE_ALL, 8'h00);
		bias <= 1'b1;
		rails <= 1'b1;
		fpull <= 2'h1;
		tick(10);
		chk("run_oe", 8, 16'h0);
		above <= 1'b1;
		link_en <= 1'b1;
		tick(10);
		chk("alert_held", 1, 16'h2);
		chk("nvm_bit", 2, 16'h1);
		fpull <= 2'h0;
		aclr <= 3'h7;
		tick(200);
		aclr <= 3'h0;
		chk("pwm_en", 4, 16'h0);
		chk("adc_valid", 9, 16'h0);
		restart <= 1'b1;
		tick(1);
		restart <= 1'b0;
		tick(4);
		chk("pwm_en", 4, 16'h0);
		wait_for(4, 16'h3, 900);
		chk("adc_valid", 9, 16'h1);
		ov <= 2'h3;
		tick(6);
		chk("gates", 5, 16'hC);
		ov <= 2'h0;
		for (ix = 0; ix < NSRC; ix++) begin
			prop_mask <= 10'h1 << ix;
			{tmg, ot, oc, uv, ov} <= 10'h1 << (2 * ix);
			tick(6);
			chk("flt_oe", 7, 16'h1);
			{tmg, ot, oc, uv, ov} <= 10'h0;
			tick(6);
		end
		prop_mask <= 10'h0;
		wait_for(4, 16'h3, 900);
		resp <= 4'h9;
		oc <= 2'h3;
		tick(8);
		chk("pwm_en", 4, 16'h0);
		oc <= 2'h0;
		wait_for(4, 16'h2, 900);
		chk("pwm_en", 4, 16'h2);
		resp <= 4'h0;
		oc <= 2'h2;
		tick(8);
		chk("pwm_en", 4, 16'h2);
		oc <= 2'h0;
		tick(4);
		// A peer pulls line 1 low; channel 1 listens and retries.
		resp <= 4'h8;
		flt_listen <= 2'h2;
		fpull <= 2'h2;
		tick(8);
		chk("pwm_en", 4, 16'h0);
		fpull <= 2'h0;
		flt_listen <= 2'h0;
		below <= 1'b1;
		above <= 1'b0;
		tick(10);
		chk("share_oe", 6, 16'h1);
		chk("pwm_en", 4, 16'h0);
		below <= 1'b0;
		above <= 1'b1;
		wait_for(4, 16'h3, 900);
		abort <= 1'b1;
		tick(1);
		abort <= 1'b0;
		tick(2);
		chk("alert_comm", 1, 16'h1);
		tick(5);
		chk("alert_comm", 1, 16'h1);
		aclr <= 3'h1;
		tick(1);
		aclr <= 3'h0;
		tick(2);
		chk("alert_comm", 1, 16'h0);
		for (ix = 0; ix < 4; ix++) begin
			drv_sel <= 2'(ix);
			tick(3);
			chk("drv_mv", 3, {2'h0, ix == 1 ? DRV_MV_7V4 : ix == 2 ?
				DRV_MV_9V0 : DRV_MV_6V3});
		end
		sync_en <= 1'b0;
		tick(4);
		chk("sync_oe", 10, 16'h0);
		sync_en <= 1'b1;
		tick(2);
		chk("sync_oe", 10, 16'h1);
		// Keep both channels on across a whole timebase period.
		tick(1100);
		test_done();
	end
endmodule : tb_pfs_powerup_seq
